// *** at_host_pkg.sv ***
// at_host_pkg: constants for the expansion bus master host interface
// assumes: single clock domain at 250 MHz, no software-visible registers
package at_host_pkg;

  // ==========================================================
  // widths and counts
  localparam int unsigned REQ_LINES = 3;
  localparam int unsigned LATCH_ADDR_W = 7;
  localparam int unsigned SETTLE_SHORT_CLKS = 10;
  localparam int unsigned SETTLE_LONG_CLKS = 20;
  localparam int unsigned SETTLE_CNT_W = 5;

  // ==========================================================
  // transfer width codes
  typedef enum logic [1:0]
  {
    WIDTH_8 = 2'h0,
    WIDTH_16 = 2'h1,
    WIDTH_32 = 2'h2
  } xfer_width_e;

  // ==========================================================
  // master sequencer states, gray along request-grant-settle-strobe-done
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_REQ = 3'h1,
    ST_SETTLE = 3'h3,
    ST_STROBE = 3'h2,
    ST_DONE = 3'h6
  } mst_state_e;

  // ==========================================================
  // reset values
  localparam logic [2:0] REQ_RESET = 3'h0;
  localparam logic [6:0] LATCH_RESET = 7'h00;

endpackage : at_host_pkg

// *** addr_latch.sv ***
// addr_latch: transparent/capture latch for upper address bits 17..23
// assumes: strobe sampled synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module addr_latch
#(
  parameter int unsigned WIDTH = 7
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // latch control
  input wire logic strobe,
  input wire logic [WIDTH-1:0] addr_in,
  // latched value
  output logic [WIDTH-1:0] addr_out
);
  import at_host_pkg::*;

  logic [WIDTH-1:0] hold_q; // value captured when strobe falls

  // ==========================================================
  // capture while strobe high, freeze on fall
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      hold_q <= WIDTH'(0);
    else if (clk_en && strobe)
      hold_q <= addr_in;
  end

  // transparent when strobe high, held value otherwise
  assign addr_out = strobe ? addr_in : hold_q;

endmodule : addr_latch
`default_nettype wire

// *** at_bus_master_host_interface.sv ***
// at_bus_master_host_interface: slave access qualification, bus acquisition,
// channel check, wait states and target width selection for the expansion bus
// assumes: all pins synchronous to clk_sys; far side arbitrates and decodes
`timescale 1ns/1ps
`default_nettype none
module at_bus_master_host_interface
#(
  parameter int unsigned REQ_N = at_host_pkg::REQ_LINES
)
(
  // clock, enable, reset
  input wire logic clk_sys,
  input wire logic clk_en,
  input wire logic reset,
  input wire logic bus_reset,
  // mode straps
  input wire logic mode_strap_a,
  input wire logic mode_strap_b,
  // slave side
  input wire logic aen,
  input wire logic reg_access,
  input wire logic bale_in,
  input wire logic [at_host_pkg::LATCH_ADDR_W-1:0] la_in,
  // internal control
  input wire logic start_req,
  input wire logic [1:0] req_sel,
  input wire logic settle_long,
  input wire logic chck_wr,
  input wire logic chck_wdata,
  // bus acquisition
  input wire logic [REQ_N-1:0] dack_n,
  output logic [REQ_N-1:0] drq,
  output logic master_n,
  output logic host_own,
  output logic bale_oe,
  // cycle control
  input wire logic iochrdy,
  input wire logic iocs16_n,
  input wire logic target_width32_select,
  output logic iord_n,
  output logic iord_oe,
  // channel check pin
  input wire logic iochck_n_in,
  output logic iochck_n,
  // status towards the local side
  output logic reg_access_ok,
  output logic [at_host_pkg::LATCH_ADDR_W-1:0] la_latched,
  output logic [1:0] xfer_width,
  output logic xfer_done,
  output logic access_error,
  output logic mode_at
);
  import at_host_pkg::*;

  // ==========================================================
  // elaboration checks
  initial
  begin
    if (REQ_N != REQ_LINES)
      $error("request line count must be three");
  end

  // ==========================================================
  // state
  mst_state_e state_q, state_d; // sequencer
  logic [SETTLE_CNT_W-1:0] cnt_q, cnt_d; // settle counter
  logic [1:0] sel_q; // chosen request line
  logic [REQ_N-1:0] drq_q;
  logic master_n_q;
  logic own_q;
  logic iord_n_q;
  logic chck_q; // channel check driven
  // pin level kept in its own flop so the output needs no inverter after the register
  logic iochck_n_q; // low while the check bit is set
  logic acc_ok_q;
  logic [LATCH_ADDR_W-1:0] la_q;
  logic [1:0] width_q;
  logic done_q;
  logic err_q;
  logic mode_q;
  logic [LATCH_ADDR_W-1:0] la_comb;

  // ==========================================================
  // decode wires
  wire logic rst_any = reset | bus_reset;
  wire logic mode_d = mode_strap_a & mode_strap_b;
  wire logic grant = ~dack_n[sel_q];
  wire logic [SETTLE_CNT_W-1:0] settle_cnt = settle_long ?
    SETTLE_CNT_W'(SETTLE_LONG_CLKS - 1) : SETTLE_CNT_W'(SETTLE_SHORT_CLKS - 1);
  wire logic chck_seen = ~iochck_n_in | chck_q;
  wire logic abort = chck_seen;
  wire logic [1:0] width_d = ~target_width32_select ? WIDTH_32 :
    (~iocs16_n ? WIDTH_16 : WIDTH_8);

  // one-hot request for the chosen line
  function automatic logic [REQ_N-1:0] onehot(input logic [1:0] s);
    onehot = REQ_N'(1) << s;
  endfunction : onehot

  // ==========================================================
  // upper address latch
  addr_latch #(.WIDTH(LATCH_ADDR_W)) u_latch
  (
    .clk_sys(clk_sys),
    .reset(rst_any),
    .clk_en(clk_en),
    .strobe(bale_in),
    .addr_in(la_in),
    .addr_out(la_comb)
  );

  // ==========================================================
  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE:
      begin
        if (start_req && mode_q && req_sel < 2'(REQ_N))
          state_d = ST_REQ;
      end
      ST_REQ:
      begin
        if (grant)
        begin
          state_d = ST_SETTLE;
          cnt_d = settle_cnt;
        end
      end
      ST_SETTLE:
      begin
        // no strobe until settle delay expires
        if (abort)
          state_d = ST_DONE;
        else if (cnt_q == '0)
          state_d = ST_STROBE;
        else
          cnt_d = cnt_q - 1'b1;
      end
      ST_STROBE:
      begin
        // hold read strobe while target not ready
        if (abort)
          state_d = ST_DONE;
        else if (iochrdy)
          state_d = ST_DONE;
      end
      ST_DONE:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ==========================================================
  // state registers
  always_ff @(posedge clk_sys)
  begin
    if (rst_any)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      sel_q <= 2'h0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (state_q == ST_IDLE && start_req)
        sel_q <= req_sel;
    end
  end

  // ==========================================================
  // bus ownership outputs
  always_ff @(posedge clk_sys)
  begin
    if (rst_any)
    begin
      drq_q <= REQ_RESET;
      master_n_q <= 1'b1;
      own_q <= 1'b0;
      iord_n_q <= 1'b1;
    end
    else if (clk_en)
    begin
      drq_q <= (state_d == ST_REQ || state_d == ST_SETTLE || state_d == ST_STROBE) ?
        onehot(state_q == ST_IDLE ? req_sel : sel_q) : REQ_RESET;
      master_n_q <= ~(state_d == ST_SETTLE || state_d == ST_STROBE);
      own_q <= (state_d == ST_SETTLE || state_d == ST_STROBE);
      iord_n_q <= ~(state_d == ST_STROBE);
    end
  end

  // ==========================================================
  // channel check, slave qualification, status
  always_ff @(posedge clk_sys)
  begin
    if (rst_any)
    begin
      chck_q <= 1'b0;
      iochck_n_q <= 1'b1;
      acc_ok_q <= 1'b0;
      la_q <= LATCH_RESET;
      width_q <= WIDTH_8;
      done_q <= 1'b0;
      err_q <= 1'b0;
      mode_q <= 1'b0;
    end
    else if (clk_en)
    begin
      mode_q <= mode_d;
      // set only by a write of the control bit, cleared by such a write or by reset or bus_reset
      if (chck_wr)
      begin
        chck_q <= chck_wdata;
        iochck_n_q <= ~chck_wdata;
      end
      acc_ok_q <= reg_access & ~aen & mode_q;
      la_q <= la_comb;
      if (state_q == ST_SETTLE)
        width_q <= width_d;
      done_q <= (state_q == ST_STROBE) && (state_d == ST_DONE);
      err_q <= (state_q == ST_STROBE || state_q == ST_SETTLE) && abort;
    end
  end

  // ==========================================================
  // outputs
  assign drq = drq_q;
  assign master_n = master_n_q;
  assign host_own = own_q;
  assign bale_oe = 1'b0;
  assign iord_n = iord_n_q;
  assign iord_oe = own_q; // drive the read strobe only while owner
  assign iochck_n = iochck_n_q;
  assign reg_access_ok = acc_ok_q;
  assign la_latched = la_q;
  assign xfer_width = width_q;
  assign xfer_done = done_q;
  assign access_error = err_q;
  assign mode_at = mode_q;

endmodule : at_bus_master_host_interface
`default_nettype wire

// *** at_bus_master_host_interface_assertions.sv ***
// checker: port rules of the expansion bus master host interface
// assumes: bound onto the design top, one clock, clk_en held high
`timescale 1ns/1ps
`default_nettype none
module at_chk
#(
  parameter int unsigned REQ_N = 3
)
(
  // clock and resets
  input wire logic clk_sys, reset, bus_reset,
  // watched pins
  input wire logic aen, reg_access, mode_at, reg_access_ok, bale_oe, master_n, host_own,
  input wire logic iord_n, iochrdy, xfer_done, chck_wr, chck_wdata, iochck_n, iochck_n_in, access_error,
  input wire logic [REQ_N-1:0] drq
);
  // ====================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || bus_reset);
  a_reg_qual: assert property (1 |=> reg_access_ok == $past(reg_access && !aen && mode_at))
    else $error("reg access qualify wrong");
  a_bale_off: assert property (!master_n |-> !bale_oe)
    else $error("strobe driven as master");
  a_own_match: assert property (host_own == !master_n)
    else $error("ownership mismatch");
  a_settle_gap: assert property ($fell(master_n) |-> iord_n [*8] ##1 iord_n [*2])
    else $error("settle too short");
  a_wait_rdy: assert property (!iord_n && !iochrdy && iochck_n && iochck_n_in |=> !iord_n && !master_n)
    else $error("cycle ended while not ready");
  a_ready_end: assert property (!iord_n && iochrdy && iochck_n && iochck_n_in |=> iord_n && master_n && xfer_done && drq == '0)
    else $error("no release after ready");
  a_chck_wr: assert property (chck_wr |=> iochck_n == !$past(chck_wdata))
    else $error("check line wrong");
  a_abort_err: assert property (!master_n && !iochck_n_in |=> access_error && master_n && !host_own)
    else $error("no abort on check");
  // main scenarios
  cover property (xfer_done);
  cover property (access_error);
  cover property (reg_access_ok);
endmodule : at_chk
bind at_bus_master_host_interface at_chk #(.REQ_N(REQ_N)) u_chk (.*);
`default_nettype wire

// *** arb_model.sv ***
// arb_model: system board arbiter and a slow I/O target
// assumes: slow gives the ready stretch of each read
`timescale 1ns/1ps
`default_nettype none
module arb_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // bus pins
  input wire logic [2:0] drq,
  input wire logic iord_n,
  input wire logic [3:0] slow,
  output logic [2:0] dack_n,
  output logic iochrdy
);
  // ====================
  logic [3:0] cnt_q; // ready countdown
  // grant mirrors request, ready held low for slow cycles
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      dack_n <= 3'h7;
      iochrdy <= 1'b1;
      cnt_q <= 4'h0;
    end
    else
    begin
      dack_n <= ~drq;
      cnt_q <= iord_n ? slow : cnt_q - 4'h1;
      iochrdy <= iord_n ? (slow == 4'h0) : (cnt_q <= 4'h1);
    end
  end
endmodule : arb_model
`default_nettype wire

// *** tb.sv ***
// tb: self-checking bench for the bus master host interface
// assumes: arb_model answers grants and ready
`timescale 1ns/1ps
`default_nettype none
module tb;
  import at_host_pkg::*;
  // ====================
  logic clk_sys = 0, clk_en = 1, reset = 1, bus_reset = 0, mode_strap_a = 1, mode_strap_b = 1;
  logic aen = 0, reg_access = 0, bale_in = 0, start_req = 0, settle_long = 0, chck_wr = 0, chck_wdata = 0;
  logic iocs16_n = 1, target_width32_select = 1, iochck_n_in = 1, iochrdy;
  logic [1:0] req_sel = 0, xfer_width;
  logic [2:0] drq, dack_n;
  logic [3:0] slow = 0;
  logic [6:0] la_in = 0, la_latched;
  logic master_n, host_own, bale_oe, iord_n, iord_oe, iochck_n, reg_access_ok, xfer_done, access_error, mode_at;
  int n_errors = 0, compares = 0;
  at_bus_master_host_interface u_at_bus_master_host_interface (.*);
  arb_model u_arb_model (.*);
  initial forever #2 clk_sys = ~clk_sys;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic t_reg;
    @(posedge clk_sys) reg_access <= 1;
    cyc(2);
    #1 chk("reg_ok", 1, 8'(reg_access_ok));
    @(posedge clk_sys) aen <= 1;
    cyc(2);
    #1 chk("reg_dma", 0, 8'(reg_access_ok));
    @(posedge clk_sys) {aen, reg_access} <= 2'b00;
    $display("t_reg done");
  endtask : t_reg
  task automatic t_latch;
    @(posedge clk_sys) {bale_in, la_in} <= 8'hda; // strobe high, address 5a
    cyc(3);
    #1 chk("la_open", 8'h5a, 8'(la_latched));
    @(posedge clk_sys) bale_in <= 0;
    @(posedge clk_sys) la_in <= 7'h25;
    cyc(3);
    #1 chk("la_held", 8'h5a, 8'(la_latched));
    $display("t_latch done");
  endtask : t_latch
  task automatic t_xfer(input logic [1:0] sel, input logic lng, w32, w16, input logic [3:0] sl, input logic [1:0] ew);
    int s;
    s = 0;
    @(posedge clk_sys) {req_sel, settle_long, target_width32_select, iocs16_n, slow, start_req} <= {sel, lng, w32, w16, sl, 1'b1};
    @(posedge clk_sys) start_req <= 0;
    #1 chk("drq", 8'(3'h1 << sel), 8'(drq));
    while (master_n && s < 9) @(posedge clk_sys) #1 s++;
    chk("iord_oe", 8'h01, 8'(iord_oe));
    chk("bale_oe", 8'h00, 8'(bale_oe));
    s = 0;
    while (iord_n && s < 40) @(posedge clk_sys) #1 s++;
    chk("settle", 1, 8'(s >= (lng ? 20 : 10) && s <= (lng ? 21 : 11)));
    s = 0;
    while (!xfer_done && s < 40) @(posedge clk_sys) #1 s++;
    chk("wait", 8'(sl + 4'h1), 8'(s));
    chk("width", 8'(ew), 8'(xfer_width));
    chk("release", 8'h01, 8'({drq, host_own, master_n}));
    chk("iord_off", 8'h00, 8'(iord_oe));
    $display("t_xfer done");
  endtask : t_xfer
  task automatic t_abort;
    int s;
    s = 0;
    @(posedge clk_sys) start_req <= 1;
    @(posedge clk_sys) start_req <= 0;
    cyc(4);
    iochck_n_in <= 0;
    while (!access_error && s < 20) @(posedge clk_sys) #1 s++;
    chk("abort_err", 8'h01, 8'(access_error));
    chk("abort", 8'h01, 8'({drq, host_own, master_n}));
    @(posedge clk_sys) iochck_n_in <= 1;
    $display("t_abort done");
  endtask : t_abort
  task automatic t_chck(input logic v);
    @(posedge clk_sys) {chck_wr, chck_wdata} <= {1'b1, v};
    @(posedge clk_sys) chck_wr <= 0;
    #1 chk("chck", 8'(!v), 8'(iochck_n));
    $display("t_chck done");
  endtask : t_chck
  task automatic t_rst_mode;
    @(posedge clk_sys) start_req <= 1;
    @(posedge clk_sys) start_req <= 0;
    cyc(4);
    bus_reset <= 1;
    @(posedge clk_sys) bus_reset <= 0;
    #1 chk("bus_rst", 8'h01, 8'({drq, host_own, master_n}));
    @(posedge clk_sys) mode_strap_a <= 0;
    cyc(2);
    start_req <= 1;
    @(posedge clk_sys) start_req <= 0;
    cyc(2);
    #1 chk("mode_off", 0, 8'({drq, mode_at}));
    @(posedge clk_sys) mode_strap_a <= 1;
    $display("t_rst_mode done");
  endtask : t_rst_mode
  initial
  begin
    cyc(20);
    reset <= 0;
    cyc(2);
    t_reg;
    t_latch;
    t_xfer(0, 0, 1, 1, 0, WIDTH_8);
    t_xfer(1, 1, 1, 0, 3, WIDTH_16);
    t_xfer(2, 0, 0, 0, 5, WIDTH_32);
    t_abort;
    t_chck(1);
    t_chck(0);
    t_rst_mode;
    stop_test;
  end
  initial
  begin
    #20000;
    n_errors++;
    stop_test;
  end
endmodule : tb
`default_nettype wire
